// ---- common/tct_defs.svh ----
// Register map, field positions, reset values and counts of the trace capture block
`ifndef TCT_DEFS_SVH
`define TCT_DEFS_SVH
// Behaviour
// - Continuous mode stores until the program stops
// - 4M-cycle memory, ring overwrite in continuous mode
// - Fill-once mode stops when memory is full
// - Centred mode halts capture after delay only
// - Delay is 0..4M cycles, capped by capacity
// - Combined conditions use at most 16 comparators
// - Repeat window: 255 before, hit, 256 after
// - Repeat-until-halt captures windows until stopped
// - Repeat-until-full halts when the last window fills memory
// - Consecutive hits mark only the first cycle
// - Step cycles recorded only in continuous mode
// - Capture/exclude qualifier only in non-repeat modes
// - Trigger only in centred/repeat; delay centred only
// - OR, combined and exceptional sources fire trigger
// - OR term enabled by default, any event fires
// - OR re-enable restores events within 16 limit
// - Combined term off at reset, one type
// - Accumulating AND: all events seen, any order
// - Simultaneous AND: all events same cycle
// - Range term: event inside address range
// - Sequential: up to 6 ordered steps, reset event
// - State term: 3 states, 9 paths, reset
`define TCT_OFF_CTRL    8'h00
`define TCT_OFF_ORMASK  8'h04
`define TCT_OFF_CBMASK  8'h08
`define TCT_OFF_RLO     8'h0c
`define TCT_OFF_RHI     8'h10
`define TCT_OFF_SEQ     8'h14
`define TCT_OFF_STCFG   8'h18
`define TCT_OFF_ST0     8'h1c
`define TCT_OFF_ST1     8'h20
`define TCT_OFF_ST2     8'h24
`define TCT_OFF_STAT    8'h28
`define TCT_OFF_TRIGA   8'h2c
`define TCT_CTRL_MODE   0
`define TCT_CTRL_OREN   3
`define TCT_CTRL_CBEN   4
`define TCT_CTRL_EXEN   5
`define TCT_CTRL_CTYPE  6
`define TCT_CTRL_DLY    9
`define TCT_CTRL_STEP   12
`define TCT_CTRL_QUAL   13
`define TCT_CTRL_FSTOP  14
`define TCT_CTRL_RST    32'h00000008
`define TCT_SEQ_LEN     24
`define TCT_SEQ_RSTEV   28
`define TCT_STCFG_RSTEV 4
`define TCT_SEQ_STEPS   3'h6
`define TCT_ST_PATHS    9
`define TCT_DLY_MAXSEL  3'h4
`define TCT_WIN_POST    8'hff
`define TCT_RESP_OKAY   2'h0
`define TCT_RESP_SLVERR 2'h2
`endif

// ---- common/tct_pkg.sv ----
// Types shared by the trace capture and trigger block
package tct_pkg;
  typedef enum logic [2:0] {TM_CONT, TM_FILL, TM_CENTRE, TM_REP_HALT, TM_REP_FULL} tct_mode_t;
  typedef enum logic [2:0] {CB_ACC, CB_SIM, CB_RANGE, CB_SEQ, CB_STATE} tct_comb_t;
endpackage

// ---- rtl/tct_top.sv ----
// Trace capture unit with trace-point trigger and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "tct_defs.svh"
module tct_top
  import tct_pkg::*;
#(
  parameter int CAP_LOG2   = 22,
  parameter int NUM_EV     = 16,
  parameter int DELAY_UNIT = 1048576
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_awaddr,
  input  wire logic                    s_awvalid,
  output logic                         s_awready,
  input  wire logic [31:0]             s_wdata,
  input  wire logic [3:0]              s_wstrb,
  input  wire logic                    s_wvalid,
  output logic                         s_wready,
  output logic [1:0]                   s_bresp,
  output logic                         s_bvalid,
  input  wire logic                    s_bready,
  input  wire logic [7:0]              s_araddr,
  input  wire logic                    s_arvalid,
  output logic                         s_arready,
  output logic [31:0]                  s_rdata,
  output logic [1:0]                   s_rresp,
  output logic                         s_rvalid,
  input  wire logic                    s_rready,
  input  wire logic                    prog_run,
  input  wire logic                    cyc_valid,
  input  wire logic [23:0]             cyc_addr,
  input  wire logic [15:0]             cyc_data,
  input  wire logic                    cyc_step,
  input  wire logic                    cyc_keep,
  input  wire logic [NUM_EV-1:0]       ev_match,
  input  wire logic                    exc_event,
  output logic                         tm_we,
  output logic [CAP_LOG2-1:0]          tm_addr,
  output logic [40:0]                  tm_data,
  output logic                         acq_active
);
  localparam logic [CAP_LOG2:0] CAP = (CAP_LOG2+1)'(1) << CAP_LOG2;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = n[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] popc(input logic [15:0] m);
    logic [4:0] c;
    c = 5'h0;
    for (int i = 0; i < 16; i++) begin
      c = c + {4'h0, m[i]};
    end
    return c;
  endfunction

  // Keeps the lowest events until the comparator budget runs out
  function automatic logic [15:0] limit(input logic [15:0] m, input logic [4:0] used);
    logic [15:0] r;
    logic [4:0]  c;
    r = 16'h0;
    c = used;
    for (int i = 0; i < 16; i++) begin
      if (m[i] && c < 5'h10) begin
        r[i] = 1'b1;
        c    = c + 5'h1;
      end
    end
    return r;
  endfunction

  logic [31:0]         ctrl_r, rlo_r, rhi_r, seq_cfg_r, stcfg_r;
  logic [15:0]         ormask_r, or_act_r, cbmask_r;
  logic [23:0]         st_r [3];
  logic                fstop_r;
  logic                aw_ok_r, w_ok_r;
  logic [7:0]          awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                run_prev_r, trig_prev_r, acq_r, trig_seen_r, post_r, full_r;
  logic [CAP_LOG2-1:0] wr_ptr_r, trig_addr_r;
  logic [CAP_LOG2:0]   cnt_r, dcnt_r;
  logic [CAP_LOG2-10:0] win_r;
  logic [7:0]          idx_r;
  logic [15:0]         acc_r, acc_nxt;
  logic [2:0]          seq_r, seq_nxt;
  logic [1:0]          stt_r, stt_nxt;
  tct_mode_t           md;
  tct_comb_t           ctype;
  logic [15:0]         ev;
  logic                cyc, start, rep, trig_mode, comb_fire, trig_raw, hit_c, keep;
  logic                wr_do, or_en, cb_en, ex_en;
  logic [2:0]          dsel;
  logic [CAP_LOG2:0]   dly_tgt;
  logic [CAP_LOG2-1:0] addr_c;
  logic [31:0]         rd_c;
  logic                rd_ok;

  assign ev        = 16'(ev_match);
  assign md        = (ctrl_r[2:0] > 3'h4) ? TM_CONT : tct_mode_t'(ctrl_r[2:0]);
  assign ctype     = tct_comb_t'(ctrl_r[`TCT_CTRL_CTYPE +: 3]);
  assign or_en     = ctrl_r[`TCT_CTRL_OREN];
  assign cb_en     = ctrl_r[`TCT_CTRL_CBEN];
  assign ex_en     = ctrl_r[`TCT_CTRL_EXEN];
  assign cyc       = cyc_valid & prog_run;
  assign start     = prog_run & ~run_prev_r;
  assign rep       = (md == TM_REP_HALT) || (md == TM_REP_FULL);
  assign trig_mode = rep || (md == TM_CENTRE);
  assign wr_do     = aw_ok_r & w_ok_r & ~s_bvalid;
  // Selector above the largest step is held at 4M; never beyond capacity
  assign dsel      = (ctrl_r[`TCT_CTRL_DLY +: 3] > `TCT_DLY_MAXSEL) ? `TCT_DLY_MAXSEL
                                                                     : ctrl_r[`TCT_CTRL_DLY +: 3];
  assign dly_tgt   = ((CAP_LOG2+1)'(dsel) * (CAP_LOG2+1)'(DELAY_UNIT) > CAP) ? CAP
                   : (CAP_LOG2+1)'(dsel) * (CAP_LOG2+1)'(DELAY_UNIT);

  // AXI4-Lite write path: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r   <= 1'b0;
      w_ok_r    <= 1'b0;
      awaddr_r  <= 8'h0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= `TCT_RESP_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_ok_r   <= 1'b1;
        awaddr_r  <= s_awaddr;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_ok_r   <= 1'b1;
        wdata_r  <= s_wdata;
        wstrb_r  <= s_wstrb;
        s_wready <= 1'b0;
      end
      if (wr_do) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (awaddr_r[1:0] != 2'h0 || awaddr_r > `TCT_OFF_ST2) ? `TCT_RESP_SLVERR
                                                                       : `TCT_RESP_OKAY;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        aw_ok_r   <= 1'b0;
        w_ok_r    <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= `TCT_CTRL_RST;
      ormask_r  <= 16'h0;
      or_act_r  <= 16'h0;
      cbmask_r  <= 16'h0;
      rlo_r     <= 32'h0;
      rhi_r     <= 32'h0;
      seq_cfg_r <= 32'h0;
      stcfg_r   <= 32'h0;
      st_r      <= '{default: 24'h0};
      fstop_r   <= 1'b0;
    end else begin
      fstop_r <= wr_do && awaddr_r == `TCT_OFF_CTRL && wstrb_r[1] && wdata_r[`TCT_CTRL_FSTOP];
      if (wr_do) begin
        case (awaddr_r)
          `TCT_OFF_CTRL: begin
            ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r) & 32'h00003fff;
            // Restored events must fit beside the combined term's comparators
            if (!or_en && wstrb_r[0] && wdata_r[`TCT_CTRL_OREN]) begin
              or_act_r <= limit(ormask_r, cb_en ? popc(cbmask_r) : 5'h0);
            end
          end
          `TCT_OFF_ORMASK: begin
            ormask_r <= 16'(merge({16'h0, ormask_r}, wdata_r, wstrb_r));
            or_act_r <= limit(16'(merge({16'h0, ormask_r}, wdata_r, wstrb_r)),
                              cb_en ? popc(cbmask_r) : 5'h0);
          end
          `TCT_OFF_CBMASK: cbmask_r  <= 16'(merge({16'h0, cbmask_r}, wdata_r, wstrb_r));
          `TCT_OFF_RLO:    rlo_r     <= merge(rlo_r, wdata_r, wstrb_r);
          `TCT_OFF_RHI:    rhi_r     <= merge(rhi_r, wdata_r, wstrb_r);
          `TCT_OFF_SEQ:    seq_cfg_r <= merge(seq_cfg_r, wdata_r, wstrb_r);
          `TCT_OFF_STCFG:  stcfg_r   <= merge(stcfg_r, wdata_r, wstrb_r);
          `TCT_OFF_ST0:    st_r[0]   <= 24'(merge({8'h0, st_r[0]}, wdata_r, wstrb_r));
          `TCT_OFF_ST1:    st_r[1]   <= 24'(merge({8'h0, st_r[1]}, wdata_r, wstrb_r));
          `TCT_OFF_ST2:    st_r[2]   <= 24'(merge({8'h0, st_r[2]}, wdata_r, wstrb_r));
          default: ;
        endcase
      end
    end
  end

  // Read path: status shows live capture state
  always_comb begin
    rd_ok = 1'b1;
    case (s_araddr)
      `TCT_OFF_CTRL:   rd_c = ctrl_r;
      `TCT_OFF_ORMASK: rd_c = {16'h0, or_act_r};
      `TCT_OFF_CBMASK: rd_c = {16'h0, cbmask_r};
      `TCT_OFF_RLO:    rd_c = rlo_r;
      `TCT_OFF_RHI:    rd_c = rhi_r;
      `TCT_OFF_SEQ:    rd_c = seq_cfg_r;
      `TCT_OFF_STCFG:  rd_c = stcfg_r;
      `TCT_OFF_ST0:    rd_c = {8'h0, st_r[0]};
      `TCT_OFF_ST1:    rd_c = {8'h0, st_r[1]};
      `TCT_OFF_ST2:    rd_c = {8'h0, st_r[2]};
      `TCT_OFF_STAT:   rd_c = {5'h0, full_r, trig_seen_r, acq_r, 24'(wr_ptr_r)};
      `TCT_OFF_TRIGA:  rd_c = 32'(trig_addr_r);
      default: begin
        rd_c  = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0;
      s_rresp   <= `TCT_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= rd_c;
      s_rresp   <= rd_ok ? `TCT_RESP_OKAY : `TCT_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
    end
  end

  // Combined term, one type at a time over the 16 comparators
  always_comb begin
    comb_fire = 1'b0;
    acc_nxt   = acc_r;
    seq_nxt   = seq_r;
    stt_nxt   = stt_r;
    case (ctype)
      CB_ACC: begin
        acc_nxt = acc_r | (ev & cbmask_r);
        if (cbmask_r != 16'h0 && acc_nxt == cbmask_r) begin
          comb_fire = 1'b1;
          acc_nxt   = 16'h0;
        end
      end
      CB_SIM: comb_fire = cbmask_r != 16'h0 && (ev & cbmask_r) == cbmask_r;
      CB_RANGE: comb_fire = |(ev & cbmask_r) && {8'h0, cyc_addr} >= rlo_r
                            && {8'h0, cyc_addr} <= rhi_r;
      CB_SEQ: begin
        if (ev[seq_cfg_r[`TCT_SEQ_RSTEV +: 4]]) begin
          seq_nxt = 3'h0;
        end else if (seq_cfg_r[`TCT_SEQ_LEN +: 3] != 3'h0
                     && ev[seq_cfg_r[{seq_r, 2'h0} +: 4]]) begin
          if (seq_r + 3'h1 >= seq_cfg_r[`TCT_SEQ_LEN +: 3] || seq_r + 3'h1 >= `TCT_SEQ_STEPS) begin
            comb_fire = 1'b1;
            seq_nxt   = 3'h0;
          end else begin
            seq_nxt = seq_r + 3'h1;
          end
        end
      end
      CB_STATE: begin
        if (ev[stcfg_r[`TCT_STCFG_RSTEV +: 4]]) begin
          stt_nxt = 2'h0;
        end else begin
          // Lowest numbered path wins when several match
          for (int p = `TCT_ST_PATHS - 1; p >= 0; p--) begin
            if (st_r[p/3][8*(p%3) +: 2] == stt_r && ev[st_r[p/3][8*(p%3)+4 +: 4]]) begin
              stt_nxt   = st_r[p/3][8*(p%3)+2 +: 2];
              comb_fire = stcfg_r[3:0] == 4'(p);
            end
          end
          if (stt_nxt > 2'h2) begin
            stt_nxt = 2'h0;
          end
        end
      end
      default: ;
    endcase
  end

  assign trig_raw = (or_en & |(ev & or_act_r)) | (cb_en & comb_fire)
                  | (ex_en & exc_event);
  assign hit_c = cyc & acq_r & trig_mode & trig_raw & ~trig_prev_r
               & ~(md == TM_CENTRE & trig_seen_r) & ~(rep & post_r);
  // Qualifier only matters outside the repeat modes; repeat modes never store step cycles
  assign keep = rep ? (cyc & acq_r & ~cyc_step)
              : (cyc & acq_r & (~ctrl_r[`TCT_CTRL_QUAL] | cyc_keep)
                 & (~cyc_step | (md == TM_CONT & ctrl_r[`TCT_CTRL_STEP])));
  assign addr_c = rep ? {win_r, post_r, idx_r} : wr_ptr_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_prev_r  <= 1'b0;
      trig_prev_r <= 1'b0;
      acc_r       <= 16'h0;
      seq_r       <= 3'h0;
      stt_r       <= 2'h0;
    end else begin
      run_prev_r <= prog_run;
      if (start) begin
        trig_prev_r <= 1'b0;
        acc_r       <= 16'h0;
        seq_r       <= 3'h0;
        stt_r       <= 2'h0;
      end else if (cyc) begin
        trig_prev_r <= trig_raw;
        acc_r       <= acc_nxt;
        seq_r       <= seq_nxt;
        stt_r       <= stt_nxt;
      end
    end
  end

  // Acquisition sequencing and trace memory write port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acq_r       <= 1'b0;
      trig_seen_r <= 1'b0;
      post_r      <= 1'b0;
      full_r      <= 1'b0;
      wr_ptr_r    <= '0;
      trig_addr_r <= '0;
      cnt_r       <= '0;
      dcnt_r      <= '0;
      win_r       <= '0;
      idx_r       <= 8'h0;
      tm_we       <= 1'b0;
      tm_addr     <= '0;
      tm_data     <= 41'h0;
      acq_active  <= 1'b0;
    end else begin
      tm_we      <= keep;
      tm_addr    <= addr_c;
      tm_data    <= {hit_c, cyc_addr, cyc_data};
      acq_active <= acq_r;
      if (start) begin
        acq_r       <= 1'b1;
        trig_seen_r <= 1'b0;
        post_r      <= 1'b0;
        full_r      <= 1'b0;
        wr_ptr_r    <= '0;
        cnt_r       <= '0;
        dcnt_r      <= '0;
        win_r       <= '0;
        idx_r       <= 8'h0;
      end else if (fstop_r) begin
        acq_r <= 1'b0;
      end else begin
        if (keep) begin
          wr_ptr_r <= wr_ptr_r + 1'b1;
          if (cnt_r != CAP) begin
            cnt_r <= cnt_r + 1'b1;
          end
          if (md == TM_FILL && cnt_r + 1'b1 == CAP) begin
            acq_r  <= 1'b0;
            full_r <= 1'b1;
          end
        end
        if (hit_c) begin
          trig_seen_r <= 1'b1;
          trig_addr_r <= addr_c;
        end
        // Capture halts only; the program keeps running
        if (md == TM_CENTRE && cyc && acq_r) begin
          if (hit_c && dly_tgt == '0) begin
            acq_r <= 1'b0;
          end else if (trig_seen_r) begin
            dcnt_r <= dcnt_r + 1'b1;
            if (dcnt_r + 1'b1 >= dly_tgt) begin
              acq_r <= 1'b0;
            end
          end
        end
        if (rep && keep) begin
          if (hit_c) begin
            post_r <= 1'b1;
            idx_r  <= 8'h0;
          end else if (post_r && idx_r == `TCT_WIN_POST) begin
            post_r <= 1'b0;
            idx_r  <= 8'h0;
            win_r  <= win_r + 1'b1;
            if (md == TM_REP_FULL && &win_r) begin
              acq_r  <= 1'b0;
              full_r <= 1'b1;
            end
          end else begin
            idx_r <= idx_r + 8'h1;
          end
        end
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cont_runs;
    md == TM_CONT && acq_r && !start && !fstop_r |=> acq_r;
  endproperty
  a_cont_runs: assert property (p_cont_runs) else $error("continuous capture stopped");

  property p_ring;
    md == TM_CONT && keep && &wr_ptr_r |=> wr_ptr_r == '0 && tm_we && &tm_addr;
  endproperty
  a_ring: assert property (p_ring) else $error("ring did not wrap");

  property p_fill_once;
    md == TM_FILL && full_r && !start |=> !keep;
  endproperty
  a_fill_once: assert property (p_fill_once) else $error("stored after full");

  property p_centre_zero;
    md == TM_CENTRE && hit_c && dly_tgt == '0 && !fstop_r |=> !acq_r ##1 !tm_we;
  endproperty
  a_centre_zero: assert property (p_centre_zero) else $error("no stop at zero delay");

  property p_window;
    rep && keep && post_r && idx_r == `TCT_WIN_POST && !start && !fstop_r
      |=> !post_r && win_r == $past(win_r) + 1'b1;
  endproperty
  a_window: assert property (p_window) else $error("window length wrong");

  property p_one_mark;
    rep && tm_we && tm_data[40] |=> !(tm_we && tm_data[40]);
  endproperty
  a_one_mark: assert property (p_one_mark) else $error("two consecutive marks");

  property p_no_trig;
    !trig_mode |-> !hit_c;
  endproperty
  a_no_trig: assert property (p_no_trig) else $error("trigger outside trigger modes");

  property p_sim;
    cyc && ctype == CB_SIM && (ev & cbmask_r) != cbmask_r |-> !comb_fire;
  endproperty
  a_sim: assert property (p_sim) else $error("partial simultaneous fire");

  property p_start_clear;
    start |=> wr_ptr_r == '0 && seq_r == 3'h0 && stt_r == 2'h0 && acq_r;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start left state");

  c_full: cover property (md == TM_FILL && $rose(full_r));
  c_centre: cover property (md == TM_CENTRE && trig_seen_r && $fell(acq_r));
  c_window: cover property (rep && $fell(post_r));
endmodule
`default_nettype wire

// ---- testbench/tct_bus_model.sv ----
// Target bus cycle source that feeds the trace capture unit
`timescale 1ns/1ps
`default_nettype none
module tct_bus_model (
  input  wire logic        aclk,
  input  wire logic        start,
  input  wire logic [15:0] n,
  input  wire logic [15:0] hit_at,
  input  wire logic [15:0] hit_ev,
  input  wire logic        dbl,
  output logic             cyc_valid,
  output logic [23:0]      cyc_addr,
  output logic [15:0]      cyc_data,
  output logic [15:0]      ev_match,
  output logic             busy
);
  logic [15:0] k_r;
  initial begin
    busy = 1'b0;
    cyc_valid = 1'b0;
    cyc_addr = 24'h000000;
    cyc_data = 16'h0000;
    ev_match = 16'h0000;
    k_r = 16'h0000;
  end
  always @(posedge aclk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      k_r <= 16'h0000;
    end else if (busy) begin
      cyc_valid <= 1'b1;
      cyc_addr <= {8'h00, k_r};
      cyc_data <= ~k_r;
      // Optional second hit on the next cycle
      ev_match <= (k_r == hit_at || (dbl && k_r == hit_at + 16'h0001)) ? hit_ev : 16'h0000;
      k_r <= k_r + 16'h0001;
      if (k_r == n - 16'h0001) busy <= 1'b0;
    end else begin
      // Idle lines toggle so stale values are never mistaken for data
      cyc_valid <= 1'b0;
      cyc_addr <= ~cyc_addr;
      cyc_data <= ~cyc_data;
      ev_match <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tct_top_tb.sv ----
// Self-checking bench for the trace capture unit
`timescale 1ns/1ps
`default_nettype none
module tct_top_tb;
  logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
  logic s_rready = 0, prog_run = 0, cyc_step = 0, exc_event = 0, start = 0, dbl = 0;
  logic cyc_keep = 1;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h00000000;
  logic [15:0] n = 16'h0000, hit_at = 16'h0000, hit_ev = 16'h0000;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, tm_we, acq_active, cyc_valid, busy;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [23:0] cyc_addr;
  logic [15:0] cyc_data, ev_match;
  logic [9:0] tm_addr, last_a;
  logic [40:0] tm_data;
  int err_count = 0, n_compared = 0, nwr = 0, nmark = 0, cyc_n = 0;
  always #25 aclk = ~aclk;
  tct_top #(.CAP_LOG2(10), .NUM_EV(16), .DELAY_UNIT(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .prog_run(prog_run), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
    .cyc_data(cyc_data), .cyc_step(cyc_step), .cyc_keep(cyc_keep), .ev_match(ev_match),
    .exc_event(exc_event), .tm_we(tm_we), .tm_addr(tm_addr), .tm_data(tm_data),
    .acq_active(acq_active));
  tct_bus_model i_bus (.aclk(aclk), .start(start), .n(n), .hit_at(hit_at), .hit_ev(hit_ev),
    .dbl(dbl), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr), .cyc_data(cyc_data),
    .ev_match(ev_match), .busy(busy));
  always @(posedge aclk) begin
    if (tm_we === 1'b1) begin
      nwr++;
      last_a = tm_addr;
      if (tm_data[40] === 1'b1) nmark++;
      chk(tm_data[39:0] === {8'h00, tm_data[31:16], ~tm_data[31:16]}, "record");
    end
  end
  task automatic end_of_test;
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Hang guard, far above the roughly 6600 cycles the run needs
  always @(posedge aclk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      err_count++;
      end_of_test;
    end
  end
  task automatic chk(input logic c, input string m);
    n_compared++;
    if (c !== 1'b1) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_awready && s_awvalid;
      tw = s_wready && s_wvalid;
      tb = s_bvalid;
      @(posedge aclk);
      if (ta) s_awvalid <= 1'b0;
      if (tw) s_wvalid <= 1'b0;
    end while (!tb);
    s_bready <= 1'b0;
    chk(s_bresp === er, "write response");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_arready && s_arvalid;
      tr = s_rvalid;
      @(posedge aclk);
      if (ta) s_arvalid <= 1'b0;
    end while (!tr);
    s_rready <= 1'b0;
    chk(s_rresp === er && s_rdata === ed, "read data");
  endtask
  // Program restart between scenarios clears the pointer and trigger state
  task automatic go(input logic [31:0] ctrl);
    @(posedge aclk);
    prog_run <= 1'b0;
    wr(8'h00, ctrl, 2'h0);
    nwr = 0;
    nmark = 0;
    prog_run <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic run(input int cnt, input int h, input logic [15:0] ev, input logic d);
    n <= 16'(cnt);
    hit_at <= 16'(h);
    hit_ev <= ev;
    dbl <= d;
    start <= 1'b1;
    @(posedge aclk);
    start <= 1'b0;
    repeat (2) @(posedge aclk);
    while (busy) @(negedge aclk);
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_regs;
    rd(8'h00, 32'h00000008, 2'h0);
    rd(8'h40, 32'h00000000, 2'h2);
    wr(8'h28, 32'h00000001, 2'h2);
  endtask
  task automatic t_cont;
    go(32'h00000000);
    run(1030, 2000, 16'h0000, 1'b0);
    chk(nwr == 1030 && last_a === 10'h005, "ring wrap");
    cyc_step <= 1'b1;
    run(10, 2000, 16'h0000, 1'b0);
    chk(nwr == 1030, "step cycle stored");
    wr(8'h00, 32'h00001000, 2'h0);
    run(10, 2000, 16'h0000, 1'b0);
    cyc_step <= 1'b0;
    chk(nwr == 1040, "step cycle lost");
  endtask
  task automatic t_fill;
    go(32'h00000001);
    run(1100, 2000, 16'h0000, 1'b0);
    chk(nwr == 1024 && acq_active === 1'b0, "fill once");
    go(32'h00001001);
    cyc_step <= 1'b1;
    run(10, 2000, 16'h0000, 1'b0);
    cyc_step <= 1'b0;
    chk(nwr == 0, "step stored outside continuous");
  endtask
  task automatic t_qual;
    cyc_keep <= 1'b0;
    go(32'h00002000);
    run(10, 2000, 16'h0000, 1'b0);
    chk(nwr == 0, "excluded cycle stored");
    go(32'h0000200b);
    run(10, 2000, 16'h0000, 1'b0);
    cyc_keep <= 1'b1;
    chk(nwr == 10, "qualifier in repeat mode");
  endtask
  task automatic t_centre;
    wr(8'h04, 32'h00000001, 2'h0);
    go(32'h0000020a);
    run(100, 20, 16'h0001, 1'b0);
    chk(nwr == 29 && nmark == 1 && acq_active === 1'b0, "post delay");
    rd(8'h2c, 32'h00000014, 2'h0);
  endtask
  task automatic t_rep(input logic [31:0] ctrl, input int bursts, input logic eacq);
    go(ctrl);
    run(600, 300, 16'h0001, 1'b1);
    chk(nmark == 1 && acq_active === 1'b1 && last_a === 10'h22a,
        "first window");
    rd(8'h2c, 32'h0000002c, 2'h0);
    repeat (bursts - 1) run(600, 300, 16'h0001, 1'b0);
    chk(nmark == bursts && acq_active === eacq, "repeat end");
    wr(8'h00, ctrl | 32'h00004000, 2'h0);
    repeat (2) @(posedge aclk);
    chk(acq_active === 1'b0, "forced stop");
  endtask
  task automatic t_trig(input logic [31:0] ctrl, input logic [15:0] e1, input logic [15:0] e2,
                        input logic x, input int em);
    go(ctrl);
    wr(8'h08, 32'h00000003, 2'h0);
    exc_event <= x;
    run(50, 10, e1, 1'b0);
    run(50, 10, e2, 1'b0);
    exc_event <= 1'b0;
    chk(nmark == em, "trigger sources");
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_cont;
    t_fill;
    t_qual;
    t_centre;
    t_rep(32'h0000000c, 2, 1'b0);
    t_rep(32'h0000000b, 3, 1'b1);
    t_trig(32'h00000052, 16'h0001, 16'h0002, 1'b0, 0);
    t_trig(32'h00000052, 16'h0001, 16'h0003, 1'b0, 1);
    t_trig(32'h00000012, 16'h0001, 16'h0002, 1'b0, 1);
    wr(8'h10, 32'h00000005, 2'h0);
    t_trig(32'h00000092, 16'h0001, 16'h0001, 1'b0, 0);
    wr(8'h10, 32'h0000000a, 2'h0);
    t_trig(32'h00000092, 16'h0001, 16'h0001, 1'b0, 1);
    wr(8'h14, 32'hf2000010, 2'h0);
    t_trig(32'h000000d2, 16'h0001, 16'h0002, 1'b0, 1);
    t_trig(32'h000000d2, 16'h0002, 16'h0001, 1'b0, 0);
    wr(8'h18, 32'h000000f1, 2'h0);
    wr(8'h1c, 32'h00001904, 2'h0);
    t_trig(32'h00000112, 16'h0001, 16'h0002, 1'b0, 1);
    t_trig(32'h00000112, 16'h0002, 16'h0001, 1'b0, 0);
    wr(8'h04, 32'h0000ffff, 2'h0);
    rd(8'h04, 32'h00003fff, 2'h0);
    t_trig(32'h00000022, 16'h0000, 16'h0000, 1'b1, 1);
    end_of_test;
  end
endmodule
`default_nettype wire
